// ---- dgx_top.sv ----
// dgx_top: debug permission gating plus private peripheral expansion port
// assumes all inputs synchronous to clk_in; permissions are static straps or
// driven by a debug access controller
`timescale 1ns/1ns
// Function
// - debug permission low disables halt debug and cross-trigger invasive actions.
// - permission high still needs halt debug enable bit for halt events.
// - instruction trace runs only while trace permission is high.
// - memory access permission enables debugger bus access port memory function.
// - without it, port registers stay reachable but system memory is blocked.
// - master identity follows select bit: 1 debugger, 0 processor.
// - identity lock high forces master identity 1.
// - identity lock low lets select bit choose 0 or 1.
// - 31-bit expansion address carries private bus address bits 19 to 2.
// - origin flag 0 for processor transfer, 1 for debugger transfer.
// - direction 1 for write, 0 for read.
// - access strobe in second and later cycles only.
// - external select only for external region, never internal debug parts.
module dgx_top
(
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // permission straps
  input  wire logic        debug_permission_in,
  input  wire logic        trace_permission_in,
  input  wire logic        debug_memory_access_permission_in,
  input  wire logic        master_identity_lock_in,
  // software control bits
  input  wire logic        halt_debug_enable_bit_in,
  input  wire logic        master_identity_select_bit_in,
  // raw debug requests from the core side
  input  wire logic        halt_request_in,
  input  wire logic        xtrig_invasive_request_in,
  input  wire logic        trace_request_in,
  // debugger bus access port request
  input  wire logic        ap_mem_request_in,
  input  wire logic        ap_reg_request_in,
  // private bus request into the expansion port
  input  wire logic        pbus_valid_in,
  input  wire logic        pbus_write_in,
  input  wire logic        pbus_from_debugger_in,
  input  wire logic        pbus_external_in,
  input  wire logic [31:0] pbus_addr_in,
  input  wire logic [31:0] pbus_wdata_in,
  output logic             pbus_ready_out,
  output logic             pbus_done_out,
  output logic [31:0]      pbus_rdata_out,
  output logic             pbus_error_out,
  // gated debug results
  output logic             halt_event_out,
  output logic             xtrig_invasive_enable_out,
  output logic             trace_enable_out,
  output logic             ap_mem_grant_out,
  output logic             ap_mem_blocked_out,
  output logic             ap_reg_grant_out,
  output logic             master_identity_out,
  // expansion port pins
  input  wire logic        expansion_ready_in,
  input  wire logic        expansion_error_in,
  input  wire logic [31:0] expansion_read_data_in,
  output logic [30:0]      expansion_address_out,
  output logic             transfer_origin_flag_out,
  output logic             expansion_direction_out,
  output logic             expansion_access_phase_out,
  output logic             expansion_external_select_out,
  output logic [31:0]      expansion_write_data_out
);
  dgx_req_if req ();

  // ==========================================================
  // permission decode, all combinational; the gated outputs below follow one clock edge later
  wire halt_ok   = debug_permission_in && halt_debug_enable_bit_in;
  wire xtrig_ok  = debug_permission_in;
  wire mem_ok    = debug_memory_access_permission_in;
  wire id_choice = master_identity_lock_in ? dgx_pkg::DGX_MASTER_DBG
                                           : master_identity_select_bit_in;

  // gated outputs registered so they come from flip-flops
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      halt_event_out            <= 1'h0;
      xtrig_invasive_enable_out <= 1'h0;
      trace_enable_out          <= 1'h0;
      ap_mem_grant_out          <= 1'h0;
      ap_mem_blocked_out        <= 1'h0;
      ap_reg_grant_out          <= 1'h0;
      master_identity_out       <= dgx_pkg::DGX_MASTER_DBG;
    end
    else
    begin
      halt_event_out            <= halt_request_in && halt_ok;
      xtrig_invasive_enable_out <= xtrig_invasive_request_in && xtrig_ok;
      trace_enable_out          <= trace_request_in && trace_permission_in;
      ap_mem_grant_out          <= ap_mem_request_in && mem_ok;
      ap_mem_blocked_out        <= ap_mem_request_in && !mem_ok;
      ap_reg_grant_out          <= ap_reg_request_in;
      master_identity_out       <= id_choice;
    end
  end

  // ==========================================================
  // expansion request; only bits 19..2 of the address are meaningful,
  // the rest read as zero so stray upper bits never reach the pins
  wire [30:0] exp_addr = {11'h000, pbus_addr_in[dgx_pkg::DGX_PBUS_HI:dgx_pkg::DGX_PBUS_LO],
                          2'h0};
  assign req.req_valid  = pbus_valid_in;
  assign req.req_write  = pbus_write_in ? dgx_pkg::DGX_DIR_WRITE : dgx_pkg::DGX_DIR_READ;
  assign req.req_origin = pbus_from_debugger_in ? dgx_pkg::DGX_ORIGIN_DBG
                                                : dgx_pkg::DGX_ORIGIN_CPU;
  assign req.req_ext    = pbus_external_in;
  assign req.req_addr   = exp_addr;
  assign req.req_wdata  = pbus_wdata_in;
  assign pbus_ready_out = req.req_ready;
  assign pbus_done_out  = req.rsp_valid;
  assign pbus_rdata_out = req.rsp_rdata;
  assign pbus_error_out = req.rsp_error;

  // apb master owns the pin timing
  dgx_apb_master u_apb
  (
    .clk_in                        (clk_in),
    .rst_n_in                      (rst_n_in),
    .req                           (req),
    .expansion_ready_in            (expansion_ready_in),
    .expansion_error_in            (expansion_error_in),
    .expansion_read_data_in        (expansion_read_data_in),
    .expansion_address_out         (expansion_address_out),
    .transfer_origin_flag_out      (transfer_origin_flag_out),
    .expansion_direction_out       (expansion_direction_out),
    .expansion_access_phase_out    (expansion_access_phase_out),
    .expansion_external_select_out (expansion_external_select_out),
    .expansion_write_data_out      (expansion_write_data_out)
  );
endmodule : dgx_top

// ---- dgx_pkg.sv ----
// dgx_pkg: constants shared by the debug gating and expansion port block
// assumes single clock domain, no register bus
package dgx_pkg;
  // ==========================================================
  // expansion bus widths, field positions and bit encodings
  localparam int          DGX_ADDR_W      = 31;
  localparam int          DGX_DATA_W      = 32;
  localparam int          DGX_PBUS_HI     = 19;
  localparam int          DGX_PBUS_LO     = 2;
  localparam logic        DGX_ORIGIN_CPU  = 1'h0;
  localparam logic        DGX_ORIGIN_DBG  = 1'h1;
  localparam logic        DGX_MASTER_CPU  = 1'h0;
  localparam logic        DGX_MASTER_DBG  = 1'h1;
  localparam logic        DGX_DIR_WRITE   = 1'h1;
  localparam logic        DGX_DIR_READ    = 1'h0;
  // ==========================================================
  // apb master states
  typedef enum logic [1:0] {DGX_IDLE, DGX_SETUP, DGX_ACCESS} dgx_state_t;
endpackage : dgx_pkg

// ---- dgx_req_if.sv ----
// dgx_req_if: request/answer bundle between gating top and apb master
// assumes both ends share clk_in
`timescale 1ns/1ns
interface dgx_req_if;
  logic        req_valid;
  logic        req_ready;
  logic        req_write;
  logic        req_origin;
  logic        req_ext;
  logic [30:0] req_addr;
  logic [31:0] req_wdata;
  logic        rsp_valid;
  logic [31:0] rsp_rdata;
  logic        rsp_error;
  modport master (input req_valid, req_write, req_origin, req_ext, req_addr, req_wdata,
                  output req_ready, rsp_valid, rsp_rdata, rsp_error);
  modport source (output req_valid, req_write, req_origin, req_ext, req_addr, req_wdata,
                  input req_ready, rsp_valid, rsp_rdata, rsp_error);
endinterface : dgx_req_if

// ---- dgx_apb_master.sv ----
// dgx_apb_master: apb style master for the external peripheral expansion port
// assumes the peripheral answers with ready and gives error alongside it
`timescale 1ns/1ns
module dgx_apb_master
(
  input  wire logic  clk_in,
  input  wire logic  rst_n_in,
  dgx_req_if.master  req,
  input  wire logic  expansion_ready_in,
  input  wire logic  expansion_error_in,
  input  wire logic [31:0] expansion_read_data_in,
  output logic [30:0] expansion_address_out,
  output logic        transfer_origin_flag_out,
  output logic        expansion_direction_out,
  output logic        expansion_access_phase_out,
  output logic        expansion_external_select_out,
  output logic [31:0] expansion_write_data_out
);
  dgx_pkg::dgx_state_t state;
  dgx_pkg::dgx_state_t next_state;
  logic                sel;
  logic                rsp_valid;
  logic [31:0]         rsp_rdata;
  logic                rsp_error;

  // ==========================================================
  // handshake decode
  wire take_req = (state == dgx_pkg::DGX_IDLE) && req.req_valid;
  wire done     = (state == dgx_pkg::DGX_ACCESS) && expansion_ready_in;
  assign req.req_ready = (state == dgx_pkg::DGX_IDLE);
  assign req.rsp_valid = rsp_valid;
  assign req.rsp_rdata = rsp_rdata;
  assign req.rsp_error = rsp_error;

  // next state: setup lasts one cycle, access waits for ready
  always_comb
  begin
    case (state)
      dgx_pkg::DGX_IDLE:   next_state = req.req_valid ? dgx_pkg::DGX_SETUP : dgx_pkg::DGX_IDLE;
      dgx_pkg::DGX_SETUP:  next_state = dgx_pkg::DGX_ACCESS;
      dgx_pkg::DGX_ACCESS: next_state = expansion_ready_in ? dgx_pkg::DGX_IDLE
                                                           : dgx_pkg::DGX_ACCESS;
      default:             next_state = dgx_pkg::DGX_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      state <= dgx_pkg::DGX_IDLE;
    else
      state <= next_state;
  end

  // address phase fields load once and hold until ready
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      expansion_address_out    <= '0;
      transfer_origin_flag_out <= dgx_pkg::DGX_ORIGIN_CPU;
      expansion_direction_out  <= dgx_pkg::DGX_DIR_READ;
      expansion_write_data_out <= '0;
      sel                      <= 1'h0;
    end
    else if (take_req)
    begin
      expansion_address_out    <= req.req_addr;
      transfer_origin_flag_out <= req.req_origin;
      expansion_direction_out  <= req.req_write;
      expansion_write_data_out <= req.req_wdata;
      sel                      <= req.req_ext;
    end
    else if (done)
      sel <= 1'h0;
  end

  // strobe only from the second cycle on
  assign expansion_access_phase_out    = (state == dgx_pkg::DGX_ACCESS);
  assign expansion_external_select_out = sel && (state != dgx_pkg::DGX_IDLE);

  // answer captured in the ready cycle, shown for one cycle
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rsp_valid <= 1'h0;
      rsp_rdata <= '0;
      rsp_error <= 1'h0;
    end
    else
    begin
      rsp_valid <= done;
      if (done)
      begin
        rsp_rdata <= expansion_read_data_in;
        rsp_error <= expansion_error_in;
      end
    end
  end
endmodule : dgx_apb_master

// ---- dgx_chk.sv ----
// dgx_chk: port level assertions for dgx_top
// assumes it is bound into dgx_top and sees one clock domain
`timescale 1ns/1ns
// ==========
// checker
module dgx_chk
(
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic        debug_permission_in,
  input wire logic        debug_memory_access_permission_in,
  input wire logic        master_identity_lock_in,
  input wire logic        halt_debug_enable_bit_in,
  input wire logic        master_identity_select_bit_in,
  input wire logic        halt_request_in,
  input wire logic        ap_mem_request_in,
  input wire logic        pbus_valid_in,
  input wire logic        pbus_write_in,
  input wire logic        pbus_from_debugger_in,
  input wire logic        pbus_external_in,
  input wire logic [31:0] pbus_addr_in,
  input wire logic        pbus_ready_out,
  input wire logic        pbus_done_out,
  input wire logic        halt_event_out,
  input wire logic        ap_mem_grant_out,
  input wire logic        ap_mem_blocked_out,
  input wire logic        master_identity_out,
  input wire logic        expansion_ready_in,
  input wire logic [30:0] expansion_address_out,
  input wire logic        transfer_origin_flag_out,
  input wire logic        expansion_direction_out,
  input wire logic        expansion_access_phase_out,
  input wire logic        expansion_external_select_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // gated outputs lag one edge, so skip the edge right after reset
  wire take = pbus_valid_in && pbus_ready_out;
  sequence s_setup; !expansion_access_phase_out; endsequence
  sequence s_access; expansion_access_phase_out; endsequence
  halt_gate_a: assert property ($past(rst_n_in) |-> halt_event_out ==
    $past(halt_request_in && debug_permission_in && halt_debug_enable_bit_in))
    else $error("halt gating wrong");
  mem_gate_a: assert property ($past(rst_n_in) |->
    ap_mem_grant_out == $past(ap_mem_request_in && debug_memory_access_permission_in)
    && ap_mem_blocked_out == $past(ap_mem_request_in && !debug_memory_access_permission_in))
    else $error("memory access gating wrong");
  ident_lock_a: assert property ($past(rst_n_in) |-> master_identity_out ==
    $past(master_identity_lock_in || master_identity_select_bit_in))
    else $error("master identity wrong");
  access_phase_a: assert property (take |=> s_setup ##1 s_access)
    else $error("access strobe out of place");
  addr_map_a: assert property (take |=>
    expansion_address_out == {11'h0, $past(pbus_addr_in[19:2]), 2'h0}
    && transfer_origin_flag_out == $past(pbus_from_debugger_in)
    && expansion_direction_out == $past(pbus_write_in))
    else $error("address origin or direction wrong");
  ext_sel_a: assert property (take |=>
    expansion_external_select_out == $past(pbus_external_in))
    else $error("external select wrong");
  pins_hold_a: assert property (expansion_access_phase_out && !expansion_ready_in |=>
    $stable(expansion_address_out) && $stable(expansion_direction_out)
    && $stable(transfer_origin_flag_out) && $stable(expansion_external_select_out))
    else $error("pins moved before ready");
  resp_done_a: assert property (expansion_access_phase_out && expansion_ready_in |=>
    pbus_done_out ##1 !pbus_done_out)
    else $error("done pulse missing");
endmodule : dgx_chk
bind dgx_top dgx_chk i_dgx_chk (.*);

// ---- dgx_periph.sv ----
// dgx_periph: external apb peripheral answering the expansion port
// assumes wait count and error choice come from the bench
`timescale 1ns/1ns
// ==========
// peripheral model
module dgx_periph
(
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        access_in,
  input  wire logic [30:0] addr_in,
  input  wire logic [3:0]  waits_in,
  input  wire logic        err_in,
  output logic             ready_out,
  output logic             error_out,
  output logic [31:0]      rdata_out
);
  logic [3:0] cnt;
  // ready one cycle after the wait count, so the master sees real stalls
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      cnt       <= 4'h0;
      ready_out <= 1'b0;
    end
    else
    begin
      ready_out <= access_in && !ready_out && cnt >= waits_in;
      cnt       <= (access_in && !ready_out) ? cnt + 4'h1 : 4'h0;
    end
  // data and error valid only with ready; data inverted and error low otherwise
  assign rdata_out = ready_out ? {addr_in, 1'b1} : ~{addr_in, 1'b1};
  assign error_out = ready_out & err_in;
endmodule : dgx_periph

// ---- dgx_tb.sv ----
// dgx_tb: self checking bench for dgx_top with a peripheral model
// assumes dgx_chk is bound in and the model answers every access
`timescale 1ns/1ns
// ==========
// bench
module testbench;
  logic clk_in, rst_n_in, debug_permission_in, trace_permission_in;
  logic debug_memory_access_permission_in, master_identity_lock_in;
  logic halt_debug_enable_bit_in, master_identity_select_bit_in, halt_request_in;
  logic xtrig_invasive_request_in, trace_request_in, ap_mem_request_in, ap_reg_request_in;
  logic pbus_valid_in, pbus_write_in, pbus_from_debugger_in, pbus_external_in;
  logic pbus_ready_out, pbus_done_out, pbus_error_out, halt_event_out;
  logic xtrig_invasive_enable_out;
  logic trace_enable_out, ap_mem_grant_out, ap_mem_blocked_out, ap_reg_grant_out;
  logic master_identity_out, expansion_ready_in, expansion_error_in, err_cfg;
  logic transfer_origin_flag_out, expansion_direction_out, expansion_access_phase_out;
  logic expansion_external_select_out;
  logic [31:0] pbus_addr_in, pbus_wdata_in, pbus_rdata_out, expansion_read_data_in;
  logic [31:0] expansion_write_data_out;
  logic [30:0] expansion_address_out;
  logic [3:0]  waits;
  int          miscompares, check_count;
  dgx_top i_dgx_top (.*);
  dgx_periph i_dgx_periph (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .access_in(expansion_access_phase_out), .addr_in(expansion_address_out),
    .waits_in(waits), .err_in(err_cfg), .ready_out(expansion_ready_in),
    .error_out(expansion_error_in), .rdata_out(expansion_read_data_in));
  initial
  begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task end_sim;
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim
  // 32 patterns of 5 bits, straps paired on shared bits, one edge of latency each
  task t_gating;
    logic [4:0] b;
    for (int i = 0; i < 32; i++)
    begin
      b = i[4:0];
      {master_identity_select_bit_in, master_identity_lock_in} = b[3:2];
      {debug_memory_access_permission_in, trace_permission_in} = b[3:2];
      {halt_debug_enable_bit_in, debug_permission_in} = b[1:0];
      {halt_request_in, xtrig_invasive_request_in, trace_request_in} = {3{b[4]}};
      {ap_mem_request_in, ap_reg_request_in} = {2{b[4]}};
      @(posedge clk_in);
      #1;
      check(halt_event_out, b[4] & b[0] & b[1]);
      check(xtrig_invasive_enable_out, b[4] & b[0]);
      check(trace_enable_out, b[4] & b[2]);
      check(ap_mem_grant_out, b[4] & b[3]);
      check(ap_mem_blocked_out, b[4] & !b[3]);
      check(ap_reg_grant_out, b[4]);
      check(master_identity_out, b[2] | b[3]);
    end
  endtask : t_gating
  // one expansion transfer, stalled by wt+1 cycles at the peripheral
  task t_xfer(input logic w, d, e, input logic [31:0] a, dat, input logic [3:0] wt,
              input logic er);
    logic [31:0] ea;
    int n;
    ea = {11'h0, a[19:2], 2'h0};
    waits = wt;
    err_cfg = er;
    {pbus_write_in, pbus_from_debugger_in, pbus_external_in} = {w, d, e};
    {pbus_addr_in, pbus_wdata_in, pbus_valid_in} = {a, dat, 1'b1};
    @(posedge clk_in);
    #1 pbus_valid_in = 1'b0;
    check(expansion_access_phase_out, 0);
    check(expansion_external_select_out, e);
    @(posedge clk_in);
    #1 check(expansion_access_phase_out, 1);
    n = 0;
    while (pbus_done_out !== 1'b1 && n < 20)
    begin
      @(posedge clk_in);
      #1 n++;
    end
    check(n < 20, 1);
    check(expansion_address_out, ea);
    check(transfer_origin_flag_out, d);
    check(expansion_direction_out, w);
    check(expansion_write_data_out, dat);
    check(pbus_error_out, er);
    if (!w) check(pbus_rdata_out, {ea[30:0], 1'b1});
  endtask : t_xfer
  initial
  begin
    {debug_permission_in, trace_permission_in, master_identity_lock_in} = 3'h0;
    {debug_memory_access_permission_in, halt_debug_enable_bit_in} = 2'h0;
    {master_identity_select_bit_in, halt_request_in, xtrig_invasive_request_in} = 3'h0;
    {trace_request_in, ap_mem_request_in, ap_reg_request_in, pbus_valid_in} = 4'h0;
    {pbus_write_in, pbus_from_debugger_in, pbus_external_in, err_cfg} = 4'h0;
    {pbus_addr_in, pbus_wdata_in, waits, rst_n_in} = 69'h0;
    repeat (20) @(posedge clk_in);
    #1 check(master_identity_out, 1);
    check(pbus_ready_out, 1);
    rst_n_in = 1'b1;
    t_gating;
    t_xfer(1, 0, 1, 32'h1234_5678, 32'hCAFE_F00D, 4'h0, 0);
    t_xfer(0, 1, 1, 32'hFFFF_FFFF, 32'h0, 4'h3, 1);
    t_xfer(0, 0, 0, 32'h000E_0004, 32'h0, 4'h1, 0);
    t_xfer(1, 1, 0, 32'h8000_0003, 32'hFFFF_FFFF, 4'h7, 1);
    end_sim;
  end
  // watchdog well past the roughly 80 cycles the tests need
  initial
  begin
    #100000;
    miscompares++;
    end_sim;
  end
endmodule : testbench
